/* File: tdcr_pkg.sv */
// shared constants and types of the tdc result read-out
package tdcr_pkg;
  // register and field widths
  localparam int RES_W = 32;
  localparam int STAT_W = 16;
  localparam int ECHO_W = 8;
  localparam int INT_W = 20;
  localparam int FRAC_W = 16;
  localparam int CNT_W = 3;
  localparam int PTR_W = 3;
  localparam int PRE_W = 14;
  localparam int GRAD_W = 16;
  localparam int OP_W = 8;
  localparam int DIV_STEPS = INT_W + FRAC_W;
  // read addresses and opcodes
  localparam logic [2:0] ADR_STAT = 3'h4;
  localparam logic [2:0] ADR_ECHO = 3'h5;
  localparam logic [4:0] OP_RD_PFX = 5'h16;
  localparam logic [OP_W-1:0] OP_INIT = 8'h70;
  // status field positions
  localparam int ST_PTR_LSB = 0;
  localparam int ST_HIT1_LSB = 3;
  localparam int ST_HIT2_LSB = 6;
  localparam int ST_TMO_BIT = 9;
  localparam int ST_PRE_BIT = 10;
  localparam int ST_OPEN_BIT = 11;
  localparam int ST_SHORT_BIT = 12;
  // hit and divider limits
  localparam logic [CNT_W-1:0] HIT_MAX = 3'h4;
  localparam logic [1:0] DIV_SH_MAX = 2'h2;
  localparam logic [FRAC_W-1:0] SAT_POS = 16'h7fff;
  localparam logic [FRAC_W-1:0] SAT_NEG = 16'h8000;
  localparam logic [RES_W-1:0] RES_OVF = 32'hffff_ffff;
  // timing, core clock 250 MHz
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TIMEOUT_NS = 1800;
  localparam int VALID_UNCAL_NS = 560;
  localparam int VALID_CAL_NS = 4600;
  localparam int TIMEOUT_CYC = TIMEOUT_NS * 1000 / CLK_PERIOD_PS;
  localparam int VALID_UNCAL_CYC = VALID_UNCAL_NS * 1000 / CLK_PERIOD_PS;
  localparam int VALID_CAL_CYC = VALID_CAL_NS * 1000 / CLK_PERIOD_PS;
  // measurement sequence
  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_MEAS, ST_CAL, ST_ALU} tdcr_state_t;
endpackage

/* File: tdcr_hit_if.sv */
// one start or stop channel between the core and its edge detector
`timescale 1ns/1ps
`default_nettype none
interface tdcr_hit_if;
  logic pin;
  logic en;
  logic invert;
  logic both;
  logic hit;
  modport src (output pin, output en, output invert, output both, input hit);
  modport det (input pin, input en, input invert, input both, output hit);
endinterface // tdcr_hit_if
`default_nettype wire

/* File: tdcr_edge.sv */
// edge selection and enable gating for one input channel
`timescale 1ns/1ps
`default_nettype none
module tdcr_edge
  import tdcr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // channel
  tdcr_hit_if.det h
);
  logic lvl;
  logic lvl_ff;
  logic hit_ff;

  // inverter in front makes rising-only also serve falling edges
  assign lvl = h.pin ^ h.invert;

  // previous level; reset loads the live level so release gives no false edge
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      lvl_ff <= lvl;
    else
      lvl_ff <= lvl;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      hit_ff <= 1'b0;
    else
      hit_ff <= h.en & (lvl ^ lvl_ff) & (h.both | lvl);
  end
  assign h.hit = hit_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_edge_gate: assert property (!h.en |=> !h.hit) else $error("hit while input disabled");
  // single-edge mode fires only on selected edge
  a_edge_pick: assert property (!h.both && h.hit |-> $past(lvl) && !$past(lvl_ff))
    else $error("hit on unselected edge");
endmodule // tdcr_edge
`default_nettype wire

/* File: tdcr_readout.sv */
// tdc result registers, status, serial read-out and range-1 measuring core
// How it works
// - four 32-bit 16.16 result registers at read addresses 0 to 3.
// - 16-bit status at address 4, bits 2-0 next free result index.
// - status bits 5-3 and 8-6 count stop channel 1 and 2 hits.
// - status bit 9 set when the measuring unit times out.
// - status bit 10 set when the 14-bit range-2 precounter overflows.
// - bits 11/12 flag open/shorted sensor; bits 15-13 read zero.
// - address 5 returns top byte of configuration register 1.
// - negative results only in range 1; range 2 unsigned.
// - uncalibrated results only in range 1; range 2 always calibrated.
// - range 1 calibrated beyond two calibration periods writes all ones.
// - calibrated results count internal reference periods, divider 1, 2 or 4.
// - calibrated results two's complement, shifted out weight 2^15 first.
// - uncalibrated 16-bit signed count in high half, low half zero.
// - range 1 measures two stop channels against one start, four hits each.
// - start begins, stop ends; 20-bit interval from coarse counter.
// - range 1 interval limited near 1.8 us, then timeout.
// - calibration measures one and two reference periods, keeps both.
// - result valid within 560 ns uncalibrated, 4.6 us calibrated.
// - each input picks rising or falling edge; only the two stop inputs can also take both edges.
// - each start/stop input has an active-high enable.
// - host sends read opcode with address; device shifts 8/16/32 bits MSB first.
// - each new result advances the load pointer by one.
`timescale 1ns/1ps
`default_nettype none
module tdcr_readout
  import tdcr_pkg::*;
#(
  parameter int REF_CYC = 8 // external reference period in core clocks
)(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // serial link
  input wire logic spi_ss_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // measurement inputs
  input wire logic start_in,
  input wire logic stop_one_in,
  input wire logic stop_two_in,
  input wire logic start_en,
  input wire logic stop_one_en,
  input wire logic stop_two_en,
  // configuration
  input wire logic cfg_calibrate,
  input wire logic long_interval_range,
  input wire logic [1:0] reference_divider_setting,
  input wire logic invert_start_input,
  input wire logic invert_stop_one_input,
  input wire logic invert_stop_two_input,
  input wire logic [1:0] both_edges_select,
  input wire logic [CNT_W-1:0] hits_expected_one,
  input wire logic [CNT_W-1:0] hits_expected_two,
  input wire logic alu_stop_diff,
  input wire logic [ECHO_W-1:0] cfg_reg1_hi,
  // temperature sensor faults
  input wire logic sensor_open,
  input wire logic sensor_short
);
  tdcr_state_t st_ff;
  tdcr_state_t nxt_st;
  logic [2:0] hit_v;
  logic [2:0] pin_v;
  logic [2:0] en_v;
  logic [2:0] inv_v;
  logic [2:0] both_v;
  logic [INT_W-1:0] icnt_ff;
  logic [INT_W-1:0] t_s1_ff;
  logic [INT_W-1:0] t_s2_ff;
  logic [CNT_W-1:0] hc1_ff;
  logic [CNT_W-1:0] hc2_ff;
  logic [GRAD_W-1:0] rcnt_ff;
  logic [PRE_W-1:0] pcnt_ff;
  logic [GRAD_W-1:0] cal1_ff;
  logic [GRAD_W-1:0] cal2_ff;
  logic tmo_ff;
  logic pre_ff;
  logic open_ff;
  logic short_ff;
  logic [PTR_W-1:0] ptr_ff;
  logic [RES_W-1:0] res_ff [4];
  logic [DIV_STEPS-1:0] dvd_ff;
  logic [GRAD_W-1:0] rem_ff;
  logic [5:0] acnt_ff;
  logic [STAT_W-1:0] stat;
  logic range2;
  logic cal_on;
  logic sel2;
  logic [1:0] div_sh;
  logic [GRAD_W-1:0] grad;
  logic [GRAD_W-1:0] gradient;
  logic meas_tmo;
  logic pre_ovf;
  logic hits_done;
  logic meas_end;
  logic have_hits;
  logic [INT_W:0] diff;
  logic [INT_W:0] mag;
  logic ovf;
  logic [GRAD_W:0] trial;
  logic ge;
  logic alu_done;
  logic wr_en;
  logic [RES_W-1:0] wr_val;
  logic init_ff;
  logic sck_d_ff;
  logic rd_ff;
  logic [3:0] bcnt_ff;
  logic [OP_W-1:0] op_ff;
  logic [RES_W-1:0] sh_ff;
  logic miso_ff;
  logic [OP_W-1:0] opn;
  logic [RES_W-1:0] rdata;
  logic sck_rise;
  logic sck_fall;
  logic [11:0] lat_ff;

  // one start and two stop channels through edge detectors
  assign pin_v = {stop_two_in, stop_one_in, start_in};
  assign en_v = {stop_two_en, stop_one_en, start_en};
  assign inv_v = {invert_stop_two_input, invert_stop_one_input, invert_start_input};
  assign both_v = {both_edges_select, 1'b0};
  tdcr_hit_if ch [3] ();
  for (genvar i = 0; i < 3; i++)
  begin : g_ch
    assign ch[i].pin = pin_v[i];
    assign ch[i].en = en_v[i];
    assign ch[i].invert = inv_v[i];
    assign ch[i].both = both_v[i];
    assign hit_v[i] = ch[i].hit;
    tdcr_edge u_edge (.core_clk(core_clk), .rstn(rstn), .h(ch[i]));
  end

  // mode decode
  // range 2 forces calibration
  assign range2 = long_interval_range;
  assign cal_on = cfg_calibrate | range2;
  // range 2 only measures stop minus start, never negative
  assign sel2 = alu_stop_diff & ~range2;
  // internal reference is external divided by 1, 2 or 4
  assign div_sh = (reference_divider_setting > DIV_SH_MAX) ? DIV_SH_MAX : reference_divider_setting;
  assign grad = GRAD_W'(REF_CYC) << div_sh;
  assign gradient = cal2_ff - cal1_ff;

  // end-of-measurement conditions
  // range 1 limit near 1.8 us
  assign meas_tmo = ~range2 & (icnt_ff == INT_W'(TIMEOUT_CYC - 1));
  assign pre_ovf = range2 & (pcnt_ff == '1) & (rcnt_ff == grad - 1'b1);
  assign hits_done = (hc1_ff >= hits_expected_one || hc1_ff == HIT_MAX)
    && (range2 || hc2_ff >= hits_expected_two || hc2_ff == HIT_MAX);
  assign meas_end = hits_done | meas_tmo | pre_ovf;
  assign have_hits = (hc1_ff != '0) && (!sel2 || hc2_ff != '0);

  // sequence control
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: nxt_st = ST_IDLE;
      ST_ARMED: if (hit_v[0]) nxt_st = ST_MEAS;
      ST_MEAS: if (meas_end) nxt_st = !have_hits ? ST_IDLE : (cal_on ? ST_CAL : ST_ALU);
      ST_CAL: if (icnt_ff == {grad, 1'b0}) nxt_st = ST_ALU;
      ST_ALU: if (alu_done) nxt_st = ST_IDLE;
    endcase
  end

  // init arms for a new start
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      st_ff <= ST_IDLE;
    else if (init_ff)
      st_ff <= ST_ARMED;
    else
      st_ff <= nxt_st;
  end

  // coarse interval counter from start, saturating
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      icnt_ff <= '0;
    else if (st_ff == ST_ARMED || (st_ff == ST_MEAS && meas_end))
      icnt_ff <= '0;
    else if (icnt_ff != '1)
      icnt_ff <= icnt_ff + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn || st_ff != ST_MEAS)
    begin
      rcnt_ff <= '0;
      pcnt_ff <= '0;
    end
    else if (rcnt_ff == grad - 1'b1)
    begin
      rcnt_ff <= '0;
      pcnt_ff <= pcnt_ff + 1'b1;
    end
    else
      rcnt_ff <= rcnt_ff + 1'b1;
  end

  // count up to four hits per stop channel, stamp the first
  // hit counts cleared on init
  // stamp is one ahead: the counter restarts a cycle after the start hit
  always_ff @(posedge core_clk)
  begin
    if (!rstn || init_ff)
    begin
      hc1_ff <= '0;
      hc2_ff <= '0;
      t_s1_ff <= '0;
      t_s2_ff <= '0;
    end
    else if (st_ff == ST_MEAS)
    begin
      if (hit_v[1] && hc1_ff != HIT_MAX)
        hc1_ff <= hc1_ff + 1'b1;
      if (hit_v[1] && hc1_ff == '0)
        t_s1_ff <= icnt_ff + 1'b1;
      if (hit_v[2] && !range2 && hc2_ff != HIT_MAX)
        hc2_ff <= hc2_ff + 1'b1;
      if (hit_v[2] && !range2 && hc2_ff == '0)
        t_s2_ff <= icnt_ff + 1'b1;
    end
  end

  // timeout flag; set wins over the init clear
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      tmo_ff <= 1'b0;
      pre_ff <= 1'b0;
    end
    else
    begin
      tmo_ff <= (st_ff == ST_MEAS && meas_tmo) | (tmo_ff & ~init_ff);
      pre_ff <= (st_ff == ST_MEAS && pre_ovf) | (pre_ff & ~init_ff);
    end
  end

  // sensor fault flags, sticky until init
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      open_ff <= 1'b0;
      short_ff <= 1'b0;
    end
    else
    begin
      open_ff <= sensor_open | (open_ff & ~init_ff);
      short_ff <= sensor_short | (short_ff & ~init_ff);
    end
  end

  // keep one- and two-period calibration counts
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      cal1_ff <= '0;
      cal2_ff <= '0;
    end
    else if (st_ff == ST_CAL && icnt_ff == INT_W'(grad))
      cal1_ff <= icnt_ff[GRAD_W-1:0];
    else if (st_ff == ST_CAL && icnt_ff == {grad, 1'b0})
      cal2_ff <= icnt_ff[GRAD_W-1:0];
  end

  // signed interval; magnitude goes through the divider
  assign diff = sel2 ? ({1'b0, t_s2_ff} - {1'b0, t_s1_ff}) : {1'b0, t_s1_ff};
  assign mag = diff[INT_W] ? -diff : diff;
  // beyond two calibration periods the quotient overflows
  assign ovf = mag >= (INT_W+1)'({gradient, 1'b0});
  assign trial = {rem_ff, dvd_ff[DIV_STEPS-1]};
  assign ge = trial >= {1'b0, gradient};
  assign alu_done = ~cal_on | (acnt_ff == 6'(DIV_STEPS));

  // restoring divider, one quotient bit a cycle; slow but tiny
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      dvd_ff <= '0;
      rem_ff <= '0;
      acnt_ff <= '0;
    end
    else if (st_ff != ST_ALU)
    begin
      dvd_ff <= {mag[INT_W-1:0], {FRAC_W{1'b0}}};
      rem_ff <= '0;
      acnt_ff <= '0;
    end
    else if (!alu_done)
    begin
      rem_ff <= ge ? GRAD_W'(trial - {1'b0, gradient}) : trial[GRAD_W-1:0];
      dvd_ff <= {dvd_ff[DIV_STEPS-2:0], ge};
      acnt_ff <= acnt_ff + 1'b1;
    end
  end

  // result formatting
  assign wr_en = (st_ff == ST_ALU) & alu_done;
  always_comb
  begin
    wr_val = '0;
    // uncalibrated saturated count in high half
    if (!cal_on)
      wr_val = {(diff[INT_W:FRAC_W-1] == '0 || diff[INT_W:FRAC_W-1] == '1) ? diff[FRAC_W-1:0]
        : (diff[INT_W] ? SAT_NEG : SAT_POS), {FRAC_W{1'b0}}};
    else if (!range2 && ovf)
      wr_val = RES_OVF;
    // two's complement for negative calibrated values
    else if (diff[INT_W] && !range2)
      wr_val = -dvd_ff[RES_W-1:0];
    else
      wr_val = dvd_ff[RES_W-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn || init_ff)
      ptr_ff <= '0;
    else if (wr_en)
      ptr_ff <= ptr_ff + 1'b1;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      res_ff <= '{default: '0};
    else if (wr_en)
      res_ff[ptr_ff[1:0]] <= wr_val;
  end

  always_comb
  begin
    stat = '0;
    stat[ST_PTR_LSB +: PTR_W] = ptr_ff;
    stat[ST_HIT1_LSB +: CNT_W] = hc1_ff;
    stat[ST_HIT2_LSB +: CNT_W] = hc2_ff;
    stat[ST_TMO_BIT] = tmo_ff;
    stat[ST_PRE_BIT] = pre_ff;
    stat[ST_OPEN_BIT] = open_ff;
    stat[ST_SHORT_BIT] = short_ff;
  end

  // serial link, sampled on the core clock
  assign sck_rise = spi_sck & ~sck_d_ff;
  assign sck_fall = ~spi_sck & sck_d_ff;
  assign opn = {op_ff[OP_W-2:0], spi_mosi};
  // echo byte; unmapped addresses read zero
  always_comb
  begin
    rdata = '0;
    if (opn[2] == 1'b0)
      rdata = res_ff[opn[1:0]];
    else if (opn[2:0] == ADR_STAT)
      rdata = {stat, {(RES_W-STAT_W){1'b0}}};
    else if (opn[2:0] == ADR_ECHO)
      rdata = {cfg_reg1_hi, {(RES_W-ECHO_W){1'b0}}};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      sck_d_ff <= 1'b0;
    else
      sck_d_ff <= spi_sck;
  end

  // opcode in on rising sck, data out MSB first on falling sck
  always_ff @(posedge core_clk)
  begin
    if (!rstn || spi_ss_n)
    begin
      bcnt_ff <= '0;
      op_ff <= '0;
      rd_ff <= 1'b0;
      sh_ff <= '0;
      init_ff <= 1'b0;
    end
    else
    begin
      init_ff <= 1'b0;
      if (sck_rise && !rd_ff && bcnt_ff != 4'(OP_W))
      begin
        op_ff <= opn;
        bcnt_ff <= bcnt_ff + 1'b1;
        if (bcnt_ff == 4'(OP_W - 1) && opn[OP_W-1:3] == OP_RD_PFX)
        begin
          rd_ff <= 1'b1;
          sh_ff <= rdata;
        end
        init_ff <= (bcnt_ff == 4'(OP_W - 1)) && (opn == OP_INIT);
      end
      else if (sck_fall && rd_ff)
        sh_ff <= {sh_ff[RES_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      miso_ff <= 1'b0;
    else if (sck_fall && rd_ff && !spi_ss_n)
      miso_ff <= sh_ff[RES_W-1];
  end
  assign spi_miso = miso_ff;
  assign spi_miso_oe = ~spi_ss_n;

  // helper: cycles spent after the last hit
  always_ff @(posedge core_clk)
  begin
    if (!rstn || (st_ff != ST_CAL && st_ff != ST_ALU))
      lat_ff <= '0;
    else
      lat_ff <= lat_ff + 1'b1;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_ptr_advance: assert property (wr_en |=> ptr_ff == $past(ptr_ff) + 1'b1)
    else $error("pointer did not advance");
  a_timeout_flag: assert property (st_ff == ST_MEAS && meas_tmo |=> stat[ST_TMO_BIT] ##1 (stat[ST_TMO_BIT] || $past(init_ff)))
    else $error("timeout flag missing");
  a_ovf_ones: assert property (wr_en && cal_on && !range2 && ovf |=> res_ff[ptr_ff[1:0] - 2'h1] == RES_OVF)
    else $error("overflow value wrong");
  a_uncal_low: assert property (wr_en && !cal_on |=> res_ff[ptr_ff[1:0] - 2'h1][FRAC_W-1:0] == '0)
    else $error("low half not cleared");
  a_valid_time: assert property (lat_ff < 12'(cal_on ? VALID_CAL_CYC : VALID_UNCAL_CYC))
    else $error("result too late");
  // init clears pointer and both hit counts
  a_init_clear: assert property (init_ff && st_ff != ST_MEAS |=> ptr_ff == '0 && hc1_ff == '0 && hc2_ff == '0)
    else $error("init did not clear state");
  a_hit_cap: assert property (hc1_ff <= HIT_MAX && hc2_ff <= HIT_MAX)
    else $error("hit count above four");
  // second calibration value twice the first
  a_cal_ratio: assert property (st_ff == ST_CAL && nxt_st == ST_ALU |=> cal2_ff == {cal1_ff[GRAD_W-2:0], 1'b0})
    else $error("calibration values inconsistent");
  a_sensor_flag: assert property (sensor_open |=> stat[ST_OPEN_BIT])
    else $error("open sensor not flagged");

  c_cal_write: cover property (wr_en && cal_on && !ovf);
  c_timeout: cover property (st_ff == ST_MEAS && meas_tmo);
  c_read_op: cover property (sck_rise && bcnt_ff == 4'(OP_W - 1) && opn[OP_W-1:3] == OP_RD_PFX);
  c_overflow: cover property (wr_en && ovf && cal_on && !range2);
endmodule // tdcr_readout
`default_nettype wire

/* File: tdcr_host_model.sv */
// host side serial master model for the result read-out
`timescale 1ns/1ps
`default_nettype none
module tdcr_host_model
  import tdcr_pkg::*;
(
  // clock
  input wire logic core_clk,
  // serial link
  output logic spi_ss_n,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // idle frame: deselected, clock parked low
  initial
  begin
    spi_ss_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end
  // wait whole core cycles
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // two core cycles per sck phase, four for the low phase while reading data, keep each level seen by the sampler
  // opcode then msb first
  task automatic xfer(input logic [OP_W-1:0] op, input int nbits, output logic [RES_W-1:0] rd);
    rd = '0;
    spi_ss_n <= 1'b0;
    step(2);
    for (int i = OP_W - 1; i >= 0; i--)
    begin
      spi_mosi <= op[i];
      step(2);
      spi_sck <= 1'b1;
      step(2);
      spi_sck <= 1'b0;
    end
    // released data line shows the inverse, not a stale bit
    spi_mosi <= ~op[0];
    for (int i = 0; i < nbits; i++)
    begin
      step(4);
      rd = {rd[RES_W-2:0], spi_miso};
      spi_sck <= 1'b1;
      step(2);
      spi_sck <= 1'b0;
    end
    step(2);
    spi_ss_n <= 1'b1;
    step(2);
  endtask
endmodule // tdcr_host_model
`default_nettype wire

/* File: tb_tdc_result_status_readout.sv */
// self-checking bench of the tdc result read-out
`timescale 1ns/1ps
`default_nettype none
module tb_tdc_result_status_readout import tdcr_pkg::*;;
  // small reference period keeps calibration short
  localparam int REFC = 2;
  logic core_clk = 1'b0;
  logic rstn;
  logic spi_ss_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic start_in, stop_one_in, stop_two_in, start_en, stop_one_en, stop_two_en;
  logic cfg_calibrate, long_interval_range, inv_s, inv_1, inv_2, alu, s_open, s_short;
  logic [1:0] div, both;
  logic [2:0] he1, he2;
  logic [7:0] echo;
  logic [15:0] lfsr_q;
  logic [31:0] rv;
  int err_total, total_checks, d, g;
  // free running core clock
  always #2 core_clk = ~core_clk;
  tdcr_readout #(.REF_CYC(REFC)) dut (.core_clk(core_clk), .rstn(rstn), .spi_ss_n(spi_ss_n), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .start_in(start_in),
    .stop_one_in(stop_one_in), .stop_two_in(stop_two_in), .start_en(start_en), .stop_one_en(stop_one_en),
    .stop_two_en(stop_two_en), .cfg_calibrate(cfg_calibrate), .long_interval_range(long_interval_range),
    .reference_divider_setting(div), .invert_start_input(inv_s), .invert_stop_one_input(inv_1),
    .invert_stop_two_input(inv_2), .both_edges_select(both), .hits_expected_one(he1),
    .hits_expected_two(he2), .alu_stop_diff(alu), .cfg_reg1_hi(echo), .sensor_open(s_open),
    .sensor_short(s_short));
  tdcr_host_model host (.core_clk(core_clk), .spi_ss_n(spi_ss_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso));
  // pseudo-random source
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // calibrated value: interval over gradient, all ones past two periods
  function automatic logic [31:0] cal_exp(input int dl, input int gr);
    return (dl >= 2 * gr) ? RES_OVF : (32'(dl) << 16) / 32'(gr);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [2:0] a, input int n);
    host.xfer({OP_RD_PFX, a}, n, rv);
  endtask
  task automatic init_tdc();
    host.xfer(OP_INIT, 0, rv);
  endtask
  // start edge at cycle 0, stop edges at t1 and t2, two-cycle pulses
  task automatic pulse(input int t1, input int t2);
    for (int i = 0; i < 90; i++)
    begin
      @(posedge core_clk);
      start_in <= (i < 2);
      stop_one_in <= (t1 > 0) && (i >= t1) && (i < t1 + 2);
      stop_two_in <= (t2 > 0) && (i >= t2) && (i < t2 + 2);
    end
  endtask
  // hang guard
  initial
  begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    {rstn, start_in, stop_one_in, stop_two_in, cfg_calibrate, long_interval_range} = 6'h00;
    {inv_s, inv_1, inv_2, alu, s_open, s_short, div, both, he2} = 13'h0000;
    {start_en, stop_one_en, stop_two_en} = 3'h7;
    he1 = 3'h1;
    err_total = 0;
    total_checks = 0;
    lfsr_q = 16'h0007;
    echo = 8'h5a;
    repeat (6) @(posedge core_clk);
    lfsr_q = lfsr_next(lfsr_q);
    rstn <= 1'b1;
    echo <= lfsr_q[7:0];
    chk({31'h0000_0000, spi_miso_oe}, 32'h0000_0000);
    rd(ADR_STAT, STAT_W);
    chk(rv, 32'h0000_0000);
    rd(ADR_ECHO, ECHO_W);
    chk(rv, {24'h00_0000, echo});
    for (int a = 6; a < 8; a++)
    begin
      rd(3'(a), RES_W);
      chk(rv, 32'h0000_0000);
    end
    // uncalibrated, read at once so data must already be valid
    for (int k = 0; k < 3; k++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      d = 3 + int'(lfsr_q[5:0]);
      init_tdc();
      pulse(d, 0);
      rd(3'h0, RES_W);
      chk(rv, {16'(d), 16'h0000});
      rd(ADR_STAT, STAT_W);
      chk(rv, 32'h0000_0009);
    end
    // stop two before stop one gives a negative count
    alu <= 1'b1;
    he2 <= 3'h1;
    init_tdc();
    pulse(20, 8);
    rd(3'h0, RES_W);
    chk(rv, 32'hfff4_0000);
    rd(ADR_STAT, STAT_W);
    chk(rv, 32'h0000_0049);
    // disabled stop: no hit, so the unit times out
    alu <= 1'b0;
    he2 <= 3'h0;
    stop_one_en <= 1'b0;
    init_tdc();
    pulse(10, 0);
    repeat (TIMEOUT_CYC) @(posedge core_clk);
    rd(ADR_STAT, STAT_W);
    chk(rv, 32'h0000_0200);
    init_tdc();
    rd(ADR_STAT, STAT_W);
    chk(rv, 32'h0000_0000);
    // inverted stop takes the falling edge
    stop_one_en <= 1'b1;
    inv_1 <= 1'b1;
    init_tdc();
    pulse(10, 0);
    rd(3'h0, RES_W);
    chk(rv, 32'h000c_0000);
    // both edges: one pulse makes two hits
    inv_1 <= 1'b0;
    both <= 2'h1;
    he1 <= 3'h2;
    init_tdc();
    pulse(10, 0);
    rd(ADR_STAT, STAT_W);
    chk(rv, 32'h0000_0011);
    // calibrated over every divider, last one at exactly two periods
    both <= 2'h0;
    he1 <= 3'h1;
    cfg_calibrate <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      g = REFC << ((k > 2) ? 2 : k);
      d = (k == 3) ? 2 * g : 1 + int'(lfsr_q % 16'(2 * g - 1));
      div <= 2'(k);
      inv_s <= lfsr_q[0];
      init_tdc();
      pulse(d + 2 * int'(lfsr_q[0]), 0);
      rd(3'h0, RES_W);
      if (k == 3)
        chk(rv, cal_exp(d, g));
      else
        chk(rv, cal_exp(d, g));
    end
    // long range is calibrated even with calibration off
    cfg_calibrate <= 1'b0;
    long_interval_range <= 1'b1;
    div <= 2'h0;
    inv_s <= 1'b0;
    init_tdc();
    pulse(5, 0);
    rd(3'h0, RES_W);
    chk(rv, 32'h0002_8000);
    init_tdc();
    pulse(0, 0);
    repeat ((1 << PRE_W) * REFC) @(posedge core_clk);
    rd(ADR_STAT, STAT_W);
    chk(rv, 32'h0000_0400);
    // sensor faults latch into the status
    long_interval_range <= 1'b0;
    init_tdc();
    s_open <= 1'b1;
    @(posedge core_clk);
    s_open <= 1'b0;
    s_short <= 1'b1;
    @(posedge core_clk);
    s_short <= 1'b0;
    rd(ADR_STAT, STAT_W);
    chk(rv, 32'h0000_1800);
    give_verdict();
  end
endmodule // tb_tdc_result_status_readout
`default_nettype wire
